// *** atb_bank.sv ***
// Purpose: Analog trim register bank driving front end, LED and oscillator selects
// Assumes: Serial port logic on CLK issues REG_REQ; no synchroniser needed
// Notes: Analog selects follow a register write by one further cycle
//
// Operation
// - Integrator field bits 12:8, reset 0x1C
// - Bits 12,11,10 enable weighted feedback capacitors
// - Resistor code 0 large, 1 mid, 2-3 small
// - Path select resets 0xADA5; 0xB065 bypasses chain
// - Led_current_trim bits 11:7, reset 0xC, linear
// - Slow oscillator trim six bits, reset 0x20
// - Slow oscillator bit 7 low powers down
// - Bit 8 swaps slow oscillator for test clock
// - Bit 14 selects increased slow oscillator range
// - Fast bypass value 1 selects test clock
// - Fast frequency trim eight bits, reset 0x5E
// - Tempco trim bits 14:8, reset 0x42
// - Reference select bits 5:4, reset 0
`timescale 1ns/1ps
module atb_bank import atb_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire atb_req_t REG_REQ,
  output atb_rsp_t REG_RSP,
  output atb_cfg_t ANALOG_CFG
);

  // Index of the register at an offset; ATB_NREG when unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    logic [2:0] idx;
    idx = 3'(ATB_NREG);
    for (int k = 0; k < ATB_NREG; k++) begin
      if (ATB_OFS_TABLE[k] == addr) begin
        idx = 3'(k);
      end
    end
    return idx;
  endfunction : reg_index

  logic [ATB_NREG-1:0][15:0] regs;
  logic [2:0] acc_idx;
  atb_bank_state_t st_q;
  atb_bank_state_t st_d;

  assign acc_idx = reg_index(REG_REQ.addr);

  // One register per offset; reset values and masks from the table
  generate
    for (genvar i = 0; i < ATB_NREG; i++) begin : g_reg
      atb_cfg_reg #(
        .RESET_VAL(ATB_RST_TABLE[i]),
        .WMASK(ATB_WM_TABLE[i])
      ) u_reg (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .wr(REG_REQ.wr && (acc_idx == 3'(i))),
        .wdata(REG_REQ.wdata), // Reserved fields kept as written, except front end bits outside ATB_WM_FRONT_END, which are forced low
        .q(regs[i])
      );
    end
  endgenerate

  // Register words to analog selects; shared by live path and reset image
  function automatic atb_cfg_t cfg_decode(input logic [ATB_NREG-1:0][15:0] r);
    atb_cfg_t cfg;
    logic [15:0] fe;
    logic [15:0] so;
    logic [15:0] ft;
    fe = r[ATB_I_FRONT_END];
    so = r[ATB_I_SLOW_OSC];
    ft = r[ATB_I_FAST_TRIM];
    cfg.reference_voltage_select = fe[ATB_VREF_LSB +: ATB_VREF_W];
    cfg.integrator_feedback_cap = fe[ATB_CAP_LSB +: 3];
    // Codes 2 and 3 alias to the smallest resistor
    case (fe[ATB_RES_LSB +: 2])
      2'h0: cfg.integ_res_onehot = 3'h4;
      2'h1: cfg.integ_res_onehot = 3'h2;
      default: cfg.integ_res_onehot = 3'h1;
    endcase
    cfg.analog_path_select = r[ATB_I_PATH_SEL];
    cfg.path_full_chain = (r[ATB_I_PATH_SEL] == ATB_PATH_FULL);
    cfg.path_tia_direct = (r[ATB_I_PATH_SEL] == ATB_PATH_TIA_ADC);
    cfg.led_current_trim = r[ATB_I_LED_CURRENT_TRIM][ATB_LED_LSB +: ATB_LED_W];
    cfg.slow_osc_trim = so[ATB_SOSC_TRIM_LSB +: ATB_SOSC_TRIM_W];
    cfg.slow_osc_run_n_powerdown = so[ATB_SOSC_RUN_BIT];
    cfg.slow_osc_bypass = so[ATB_SOSC_BYP_BIT];
    cfg.slow_osc_range_select = so[ATB_SOSC_RANGE_BIT];
    // Only code 1 is defined as external; other codes stay internal
    cfg.fast_osc_bypass =
      (r[ATB_I_FAST_BYP][ATB_FOSC_BYP_LSB +: 2] == ATB_FOSC_BYP_EXT);
    cfg.fast_osc_freq_trim = ft[ATB_FOSC_FREQ_LSB +: 8];
    cfg.fast_osc_tempco_trim = ft[ATB_FOSC_TC_LSB +: ATB_FOSC_TC_W];
    return cfg;
  endfunction : cfg_decode

  // Reset image from the reset words, so selects can never disagree with them
  localparam atb_cfg_t cfg_rst = cfg_decode(ATB_RST_TABLE & ATB_WM_TABLE);

  // Read answer and registered copy of the analog selects
  always_comb begin
    st_d = st_q;
    // Unmapped offsets answer zero rather than stalling the port
    st_d.rsp.valid = REG_REQ.rd;
    if (REG_REQ.rd) begin
      st_d.rsp.data = (acc_idx < 3'(ATB_NREG)) ? regs[acc_idx] : 16'h0000;
    end
    st_d.cfg = cfg_decode(regs);
  end

  // Selects reset to the decode of the register reset words
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= '{cfg: cfg_rst, rsp: '0};
    end else if (CE) begin
      st_q <= st_d;
    end
  end

  assign REG_RSP = st_q.rsp;
  assign ANALOG_CFG = st_q.cfg;

endmodule : atb_bank

// *** atb_pkg.sv ***
// Purpose: Shared constants and types for the analog trim register bank
// Assumes: Register index space of 8 bits, 16-bit register data
// Notes: Offsets are register indices on the serial configuration port
package atb_pkg;

  // Register geometry
  localparam int ATB_DW = 16;
  localparam int ATB_AW = 8;
  localparam int ATB_NREG = 7;

  // Register offsets
  localparam logic [7:0] ATB_OFS_FRONT_END = 8'h12;
  localparam logic [7:0] ATB_OFS_PATH_SEL = 8'h13;
  localparam logic [7:0] ATB_OFS_BIAS_RSVD = 8'h14;
  localparam logic [7:0] ATB_OFS_LED_CURRENT_TRIM = 8'h16;
  localparam logic [7:0] ATB_OFS_SLOW_OSC = 8'h18;
  localparam logic [7:0] ATB_OFS_FAST_BYP = 8'h19;
  localparam logic [7:0] ATB_OFS_FAST_TRIM = 8'h1A;

  // Values after reset, whole register
  localparam logic [15:0] ATB_RST_FRONT_END = 16'h1C00;
  localparam logic [15:0] ATB_RST_PATH_SEL = 16'hADA5;
  localparam logic [15:0] ATB_RST_BIAS_RSVD = 16'h0080;
  localparam logic [15:0] ATB_RST_LED_CURRENT_TRIM = 16'h0600;
  localparam logic [15:0] ATB_RST_SLOW_OSC = 16'h3620;
  localparam logic [15:0] ATB_RST_FAST_BYP = 16'h0004;
  localparam logic [15:0] ATB_RST_FAST_TRIM = 16'h425E;

  // Writable bits; unused bits read as zero
  localparam logic [15:0] ATB_WM_FRONT_END = 16'h7F3F;
  localparam logic [15:0] ATB_WM_ALL = 16'hFFFF;

  // Path select codes
  localparam logic [15:0] ATB_PATH_FULL = 16'hADA5;
  localparam logic [15:0] ATB_PATH_TIA_ADC = 16'hB065;

  // Field positions (least significant bit) and widths
  localparam int ATB_VREF_LSB = 4;
  localparam int ATB_VREF_W = 2;
  localparam int ATB_RES_LSB = 8;
  localparam int ATB_CAP_LSB = 10;
  localparam int ATB_LED_LSB = 7;
  localparam int ATB_LED_W = 5;
  localparam int ATB_SOSC_TRIM_LSB = 0;
  localparam int ATB_SOSC_TRIM_W = 6;
  localparam int ATB_SOSC_RUN_BIT = 7;
  localparam int ATB_SOSC_BYP_BIT = 8;
  localparam int ATB_SOSC_RANGE_BIT = 14;
  localparam int ATB_FOSC_BYP_LSB = 0;
  localparam logic [1:0] ATB_FOSC_BYP_EXT = 2'h1;
  localparam int ATB_FOSC_FREQ_LSB = 0;
  localparam int ATB_FOSC_TC_LSB = 8;
  localparam int ATB_FOSC_TC_W = 7;

  // Index order of the registers inside the bank
  localparam int ATB_I_FRONT_END = 0;
  localparam int ATB_I_PATH_SEL = 1;
  localparam int ATB_I_BIAS_RSVD = 2;
  localparam int ATB_I_LED_CURRENT_TRIM = 3;
  localparam int ATB_I_SLOW_OSC = 4;
  localparam int ATB_I_FAST_BYP = 5;
  localparam int ATB_I_FAST_TRIM = 6;

  localparam logic [ATB_NREG-1:0][7:0] ATB_OFS_TABLE = {
    ATB_OFS_FAST_TRIM, ATB_OFS_FAST_BYP, ATB_OFS_SLOW_OSC, ATB_OFS_LED_CURRENT_TRIM,
    ATB_OFS_BIAS_RSVD, ATB_OFS_PATH_SEL, ATB_OFS_FRONT_END};
  localparam logic [ATB_NREG-1:0][15:0] ATB_RST_TABLE = {
    ATB_RST_FAST_TRIM, ATB_RST_FAST_BYP, ATB_RST_SLOW_OSC, ATB_RST_LED_CURRENT_TRIM,
    ATB_RST_BIAS_RSVD, ATB_RST_PATH_SEL, ATB_RST_FRONT_END};
  localparam logic [ATB_NREG-1:0][15:0] ATB_WM_TABLE = {
    ATB_WM_ALL, ATB_WM_ALL, ATB_WM_ALL, ATB_WM_ALL,
    ATB_WM_ALL, ATB_WM_ALL, ATB_WM_FRONT_END};

  // Static selects handed to the analog circuits
  typedef struct packed {
    logic [1:0] reference_voltage_select;
    logic [2:0] integrator_feedback_cap;
    logic [2:0] integ_res_onehot;
    logic path_full_chain;
    logic path_tia_direct;
    logic [15:0] analog_path_select;
    logic [4:0] led_current_trim;
    logic [5:0] slow_osc_trim;
    logic slow_osc_run_n_powerdown;
    logic slow_osc_bypass;
    logic slow_osc_range_select;
    logic fast_osc_bypass;
    logic [7:0] fast_osc_freq_trim;
    logic [6:0] fast_osc_tempco_trim;
  } atb_cfg_t;

  // Register access request from the serial port logic
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } atb_req_t;

  // Read answer
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } atb_rsp_t;

  typedef struct packed {
    logic [15:0] val;
  } atb_reg_state_t;

  typedef struct packed {
    atb_cfg_t cfg;
    atb_rsp_t rsp;
  } atb_bank_state_t;

endpackage : atb_pkg

// *** atb_cfg_reg.sv ***
// Purpose: One 16-bit configuration register with reset value and write mask
// Assumes: Write strobe and data already decoded for this register
// Notes: Bits outside the mask hold zero and ignore writes
`timescale 1ns/1ps
module atb_cfg_reg import atb_pkg::*; #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WMASK = 16'hFFFF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wr,
  input wire logic [15:0] wdata,
  output logic [15:0] q
);

  atb_reg_state_t st_q;
  atb_reg_state_t st_d;

  // Whole-word write; masked bits forced low
  always_comb begin
    st_d = st_q;
    if (wr) begin
      st_d.val = wdata & WMASK;
    end
  end

  // Frozen while clock enable is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{val: RESET_VAL & WMASK};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.val;

endmodule : atb_cfg_reg

// *** atb_bank_asserts.sv ***
// Purpose: Port checks for the analog trim register bank
// Assumes: One clock domain; CE low freezes all state
// Notes: Decode checks need CE high on the edge after the write
`timescale 1ns/1ps
module atb_bank_chk import atb_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire atb_req_t REG_REQ,
  input wire atb_rsp_t REG_RSP,
  input wire atb_cfg_t ANALOG_CFG
);
  atb_cfg_t c;
  logic [7:0] wa;
  logic [15:0] d1_q;
  logic [15:0] d2_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Offset of a taken write, else zero, which is unmapped
  assign wa = (CE && REG_REQ.wr) ? REG_REQ.addr : 8'h00;
  assign c = ANALOG_CFG;
  // Data two edges back lines up with the decode flop
  always_ff @(posedge CLK) begin
    d1_q <= REG_REQ.wdata;
    d2_q <= d1_q;
  end
  front_mask_a: assert property (
    CE && REG_REQ.rd && REG_REQ.addr == ATB_OFS_FRONT_END |=> REG_RSP.valid
    && (REG_RSP.data & ~ATB_WM_FRONT_END) == 16'h0000) else $error("bad front mask");
  front_dec_a: assert property (
    wa == ATB_OFS_FRONT_END ##1 CE |=> {c.integrator_feedback_cap,
    c.reference_voltage_select} == {d2_q[12:10], d2_q[5:4]}) else $error("bad cap or vref");
  res_dec_a: assert property (
    wa == ATB_OFS_FRONT_END ##1 CE |=> c.integ_res_onehot
    == (d2_q[9] ? 3'h1 : (d2_q[8] ? 3'h2 : 3'h4))) else $error("bad resistor select");
  path_dec_a: assert property (
    c.path_full_chain == (c.analog_path_select == ATB_PATH_FULL)
    && c.path_tia_direct == (c.analog_path_select == ATB_PATH_TIA_ADC))
    else $error("bad path decode");
  path_rdbk_a: assert property (
    wa == ATB_OFS_PATH_SEL ##1 wa == 8'h00 ##1 CE && REG_REQ.rd && !REG_REQ.wr
    && REG_REQ.addr == ATB_OFS_PATH_SEL |=> REG_RSP.data == $past(REG_REQ.wdata, 3))
    else $error("bad path readback");
  led_dec_a: assert property (
    wa == ATB_OFS_LED_CURRENT_TRIM ##1 CE |=> c.led_current_trim == d2_q[11:7])
    else $error("bad led_current_trim");
  sosc_dec_a: assert property (
    wa == ATB_OFS_SLOW_OSC ##1 CE |=> {c.slow_osc_range_select, c.slow_osc_bypass,
    c.slow_osc_run_n_powerdown, c.slow_osc_trim} == {d2_q[14], d2_q[8:7], d2_q[5:0]})
    else $error("bad slow osc decode");
  fbyp_dec_a: assert property (
    wa == ATB_OFS_FAST_BYP ##1 CE |=> c.fast_osc_bypass == (d2_q[1:0] == ATB_FOSC_BYP_EXT))
    else $error("bad fast bypass");
  fosc_dec_a: assert property (
    wa == ATB_OFS_FAST_TRIM ##1 CE |=> {c.fast_osc_tempco_trim, c.fast_osc_freq_trim}
    == d2_q[14:0]) else $error("bad fast trim");
endmodule : atb_bank_chk

bind atb_bank atb_bank_chk u_chk (.CLK(CLK), .RST_B(RST_B), .CE(CE), .REG_REQ(REG_REQ),
  .REG_RSP(REG_RSP), .ANALOG_CFG(ANALOG_CFG));

// *** atb_bank_bench.sv ***
// Purpose: Self-checking bench for the analog trim register bank
// Assumes: Inputs change by NBA on rising CLK
// Notes: Rows hold write/readback pairs; odd cases follow
`timescale 1ns/1ps
module atb_bank_bench import atb_pkg::*; ();
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } atb_row_t;
  logic clk;
  logic rst_b;
  logic ce;
  atb_req_t req;
  atb_rsp_t rsp;
  atb_cfg_t ac;
  logic [15:0] fe_v;
  logic [15:0] so_v;
  int err_count;
  int compares;
  int cycles;
  // Reserved fields keep defaults; 0x15 is unmapped
  atb_row_t rows [12] = '{'{8'h12, 16'h0030, 16'h0030}, '{8'h12, 16'h1000, 16'h1000},
    '{8'h12, 16'h0910, 16'h0910}, '{8'h12, 16'h0A20, 16'h0A20}, '{8'h12, 16'h1F3F, 16'h1F3F},
    '{8'h13, 16'hB065, 16'hB065}, '{8'h16, 16'h0F80, 16'h0F80}, '{8'h18, 16'h7780, 16'h7780},
    '{8'h19, 16'h0005, 16'h0005}, '{8'h1A, 16'h7FFF, 16'h7FFF}, '{8'h15, 16'h1234, 16'h0000},
    '{8'h14, 16'h0080, 16'h0080}};
  // Packed views of the selects
  assign fe_v = {8'h00, ac.integrator_feedback_cap, ac.integ_res_onehot,
    ac.reference_voltage_select};
  assign so_v = {7'h00, ac.slow_osc_range_select, ac.slow_osc_bypass,
    ac.slow_osc_run_n_powerdown, ac.slow_osc_trim};
  atb_bank dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .REG_REQ(req), .REG_RSP(rsp),
    .ANALOG_CFG(ac));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, far above the 79 cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One request, then an idle cycle; answer sampled after it settles
  task automatic acc(input logic w, input logic r, input logic [7:0] a,
    input logic [15:0] d, input logic [15:0] e);
    @(posedge clk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
    if (r) begin
      chk("valid", {15'h0000, rsp.valid}, 16'h0001);
      chk("rdata", rsp.data, e);
    end
  endtask : acc
  task automatic cfg_chk(input logic [15:0] fe, input logic [15:0] pt, input logic [15:0] ld,
    input logic [15:0] so, input logic [15:0] fo, input logic fb);
    chk("front_end", fe_v, fe);
    chk("path", {14'h0000, ac.path_tia_direct, ac.path_full_chain}, pt);
    chk("path_word", ac.analog_path_select, pt[1] ? ATB_PATH_TIA_ADC : ATB_PATH_FULL);
    chk("led", {11'h000, ac.led_current_trim}, ld);
    chk("slow_osc", so_v, so);
    chk("fast_osc", {1'h0, ac.fast_osc_tempco_trim, ac.fast_osc_freq_trim}, fo);
    chk("fast_byp", {15'h0000, ac.fast_osc_bypass}, {15'h0000, fb});
  endtask : cfg_chk
  task automatic test_done();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // Reset values, row table, then the awkward cases
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    req = '0;
    repeat (5) @(posedge clk);
    cfg_chk(16'h00F0, 16'h0001, 16'h000C, 16'h0020, 16'h425E, 1'b0);
    rst_b <= 1'b1;
    for (int i = 0; i < ATB_NREG; i++) begin
      acc(1'b0, 1'b1, ATB_OFS_TABLE[i], 16'h0000, ATB_RST_TABLE[i]);
    end
    foreach (rows[i]) begin
      acc(1'b1, 1'b0, rows[i].a, rows[i].d, 16'h0000);
      acc(1'b0, 1'b1, rows[i].a, 16'h0000, rows[i].e);
    end
    cfg_chk(16'h00E7, 16'h0002, 16'h001F, 16'h01C0, 16'h7FFF, 1'b1);
    // A write while CE is low must be dropped
    @(posedge clk);
    ce <= 1'b0;
    req <= '{wr: 1'b1, rd: 1'b0, addr: ATB_OFS_PATH_SEL, wdata: 16'h1111};
    @(posedge clk);
    ce <= 1'b1;
    req <= '0;
    acc(1'b0, 1'b1, ATB_OFS_PATH_SEL, 16'h0000, 16'hB065);
    // Write and read together return the old word
    acc(1'b1, 1'b1, ATB_OFS_LED_CURRENT_TRIM, 16'h0600, 16'h0F80);
    acc(1'b0, 1'b1, ATB_OFS_LED_CURRENT_TRIM, 16'h0000, 16'h0600);
    // Reset in mid-run restores every select
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    cfg_chk(16'h00F0, 16'h0001, 16'h000C, 16'h0020, 16'h425E, 1'b0);
    rst_b <= 1'b1;
    acc(1'b0, 1'b1, ATB_OFS_PATH_SEL, 16'h0000, 16'hADA5);
    test_done();
  end
endmodule : atb_bank_bench
